// [hw/ddff_consts.svh]
// Constants for the dual edge-triggered storage block
`ifndef DDFF_CONSTS_SVH
`define DDFF_CONSTS_SVH

`define DDFF_NUM_ELEM 2
`define DDFF_Q_RST 1'h0
`define DDFF_QN_RST 1'h1
`define DDFF_CLK_PREV_RST 1'h1
`define DDFF_BOTH_RST 1'h0
`define DDFF_SETTLE_Q 1'h0

`endif

// [hw/ddff_pkg.sv]
// Types for the dual edge-triggered storage block
package ddff_pkg;

    typedef struct packed {
        logic data;
        logic elem_clk;
        logic async_set_n;
        logic async_clear_n;
    } ddff_in_t;

    typedef struct packed {
        logic q;
        logic q_n;
    } ddff_out_t;

    typedef enum logic [1:0] {
        DDFF_CTRL_RUN,
        DDFF_CTRL_SET,
        DDFF_CTRL_CLEAR,
        DDFF_CTRL_BOTH
    } ddff_ctrl_t;

endpackage

// [hw/ddff_top.sv]
// Dual edge-triggered storage elements with asynchronous-style set and clear
`timescale 1ns/1ps
`default_nettype none
`include "ddff_consts.svh"

module ddff_top (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Element pins
    input wire ddff_pkg::ddff_in_t [`DDFF_NUM_ELEM-1:0] elem_in,
    // Element outputs
    output wire ddff_pkg::ddff_out_t [`DDFF_NUM_ELEM-1:0] elem_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Per-element storage
    ////////////////////////////////////////////////////////////////////////////

    genvar gi;

    generate
        for (gi = 0; gi < `DDFF_NUM_ELEM; gi = gi + 1) begin : g_elem

            ////////////////////////////////////////////////////////////////////
            // Local signals
            ////////////////////////////////////////////////////////////////////

            // Pins and decoded controls
            ddff_pkg::ddff_in_t pin;
            logic set_act;
            logic clear_act;
            ddff_pkg::ddff_ctrl_t ctrl;

            // Stored state
            logic clk_prev_q;
            logic both_q;
            logic q_q;
            logic q_n_q;

            // Per-cycle events
            logic run;
            logic rise;
            logic settle;
            logic load;

            ////////////////////////////////////////////////////////////////////
            // Pin decode
            ////////////////////////////////////////////////////////////////////

            // One element's pins, all synchronous levels
            assign pin = elem_in[gi];

            // Controls are active low on the pins
            assign set_act = ~pin.async_set_n;
            assign clear_act = ~pin.async_clear_n;

            always_comb begin
                case ({set_act, clear_act})
                    2'h3: begin
                        ctrl = ddff_pkg::DDFF_CTRL_BOTH;
                    end

                    2'h2: begin
                        ctrl = ddff_pkg::DDFF_CTRL_SET;
                    end

                    2'h1: begin
                        ctrl = ddff_pkg::DDFF_CTRL_CLEAR;
                    end

                    default: begin
                        ctrl = ddff_pkg::DDFF_CTRL_RUN;
                    end
                endcase
            end

            ////////////////////////////////////////////////////////////////////
            // Edge and settle detection
            ////////////////////////////////////////////////////////////////////

            assign run = (ctrl == ddff_pkg::DDFF_CTRL_RUN);

            // Element clock pin is sampled; an edge is low then high
            assign rise = pin.elem_clk & ~clk_prev_q;

            // Joint release from both asserted settles cleared;
            // a rising edge in that same cycle is lost
            assign settle = run & both_q;

            assign load = run & ~both_q & rise;

            ////////////////////////////////////////////////////////////////////
            // Edge history
            ////////////////////////////////////////////////////////////////////

            // Starts high so leaving reset with the pin high is no edge
            // Frozen with clk_en low, so a paused edge still counts
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    clk_prev_q <= `DDFF_CLK_PREV_RST;
                end else if (clk_en) begin
                    clk_prev_q <= pin.elem_clk;
                end
            end

            ////////////////////////////////////////////////////////////////////
            // Both-asserted memory
            ////////////////////////////////////////////////////////////////////

            // Remembers the unstable both-asserted condition
            // so that a joint release can be told apart
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    both_q <= `DDFF_BOTH_RST;
                end else if (clk_en) begin
                    both_q <= (ctrl == ddff_pkg::DDFF_CTRL_BOTH);
                end
            end

            ////////////////////////////////////////////////////////////////////
            // True output
            ////////////////////////////////////////////////////////////////////

            // Controls are sampled like any pin, so they act one clock
            // late; a pulse between two clock edges is not seen
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    q_q <= `DDFF_Q_RST;
                end else if (clk_en) begin
                    case (ctrl)
                        ddff_pkg::DDFF_CTRL_SET: begin
                            q_q <= 1'h1;
                        end

                        ddff_pkg::DDFF_CTRL_CLEAR: begin
                            q_q <= 1'h0;
                        end

                        ddff_pkg::DDFF_CTRL_BOTH: begin
                            q_q <= 1'h1;
                        end

                        ddff_pkg::DDFF_CTRL_RUN: begin
                            // Settle first, then a clock edge, else hold
                            if (settle) begin
                                q_q <= `DDFF_SETTLE_Q;
                            end else if (load) begin
                                q_q <= pin.data;
                            end else begin
                                q_q <= q_q;
                            end
                        end

                        // Unreachable: every control state is decoded
                        default: begin
                            q_q <= q_q;
                        end
                    endcase
                end
            end

            ////////////////////////////////////////////////////////////////////
            // Complementary output
            ////////////////////////////////////////////////////////////////////

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    q_n_q <= `DDFF_QN_RST;
                end else if (clk_en) begin
                    case (ctrl)
                        ddff_pkg::DDFF_CTRL_SET: begin
                            q_n_q <= 1'h0;
                        end

                        ddff_pkg::DDFF_CTRL_CLEAR: begin
                            q_n_q <= 1'h1;
                        end

                        ddff_pkg::DDFF_CTRL_BOTH: begin
                            q_n_q <= 1'h1;
                        end

                        ddff_pkg::DDFF_CTRL_RUN: begin
                            // Settle first, then a clock edge, else hold
                            if (settle) begin
                                q_n_q <= ~`DDFF_SETTLE_Q;
                            end else if (load) begin
                                q_n_q <= ~pin.data;
                            end else begin
                                q_n_q <= q_n_q;
                            end
                        end

                        // Unreachable: every control state is decoded
                        default: begin
                            q_n_q <= q_n_q;
                        end
                    endcase
                end
            end

            ////////////////////////////////////////////////////////////////////
            // Outputs
            ////////////////////////////////////////////////////////////////////

            assign elem_out[gi].q = q_q;
            assign elem_out[gi].q_n = q_n_q;

        end
    endgenerate

endmodule

`default_nettype wire

// [test/ddff_assertions.sv]
// Checker for the dual storage block
`timescale 1ns/1ps
`default_nettype none
module ddff_chk (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Element pins and outputs
    input wire ddff_pkg::ddff_in_t [1:0] elem_in,
    input wire ddff_pkg::ddff_out_t [1:0] elem_out
);
    wire logic s = elem_in[0].async_set_n;
    wire logic c = elem_in[0].async_clear_n;
    wire logic k = elem_in[0].elem_clk;
    wire logic [1:0] o = elem_out[0];
    // Edge taken by the design, reset released
    wire logic en = clk_en & rst_n;
    // Controls idle and not leaving the both-low state
    wire logic run = en & s & c & ~&o;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_set; en & !s & c |=> o == 2'h2; endproperty
    a_set: assert property (p_set) else $error("set");
    property p_clr; en & s & !c |=> o == 2'h1; endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_both; en & !s & !c |=> o == 2'h3; endproperty
    a_both: assert property (p_both) else $error("both");
    property p_rel; en & s & c & &o |=> o == 2'h1; endproperty
    a_rel: assert property (p_rel) else $error("release");
    property p_load; run & k & !$past(k) & $past(clk_en) & $past(rst_n)
        |=> o == ($past(elem_in[0].data) ? 2'h2 : 2'h1); endproperty
    a_load: assert property (p_load) else $error("load");
    property p_hold; run & !k |=> $stable(o); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_edge; run & k & $past(k) & $past(clk_en) |=> $stable(o); endproperty
    a_edge: assert property (p_edge) else $error("no edge");
    property p_ind; en & !elem_in[1].async_set_n & elem_in[1].async_clear_n
        |=> elem_out[1] == 2'h2; endproperty
    a_ind: assert property (p_ind) else $error("second");
    property p_ind_clr; en & elem_in[1].async_set_n & !elem_in[1].async_clear_n
        |=> elem_out[1] == 2'h1; endproperty
    a_ind_clr: assert property (p_ind_clr) else $error("second clear");
endmodule
bind ddff_top ddff_chk u_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .elem_in(elem_in), .elem_out(elem_out));
`default_nettype wire

// [test/ddff_drv.sv]
// Surrounding logic presenting pin levels
`timescale 1ns/1ps
`default_nettype none
module ddff_drv (
    // Requested levels
    input wire logic [7:0] req,
    // Element pins
    output wire ddff_pkg::ddff_in_t [1:0] pins
);
    assign pins = req;
endmodule
`default_nettype wire

// [test/ddff_top_tb.sv]
// Random bench for the dual storage block
`timescale 1ns/1ps
`default_nettype none
module ddff_top_tb;
    logic clk = 0, rst_n = 0, clk_en = 0;
    logic [7:0] req = 8'h33;
    logic [3:0] exp_q = 4'h5;
    logic [1:0] pclk = 2'h3;
    int fails = 0, compares = 0;
    ddff_pkg::ddff_in_t [1:0] pins;
    ddff_pkg::ddff_out_t [1:0] elem_out;
    ddff_drv u_drv (.req(req), .pins(pins));
    ddff_top u_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .elem_in(pins),
        .elem_out(elem_out));
    initial forever #5 clk = ~clk;
    function automatic logic [1:0] nxt(logic [3:0] p, logic [1:0] s, logic pc);
        if (!p[1] || !p[0]) return {!p[1], !p[0]};
        if (&s) return 2'h1;
        if (p[2] && !pc) return {p[3], !p[3]};
        return s;
    endfunction
    task chk(input logic [3:0] seen, input logic [3:0] e);
        compares++;
        if (seen !== e) begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, e);
        end
    endtask
    task end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h2168));
        repeat (2) @(posedge clk);
        for (int t = 0; t < 3; t++) begin
            repeat (600) begin
                @(posedge clk);
                for (int e = 0; e < 2; e++) begin
                    if (!rst_n) begin
                        exp_q[2*e+:2] = 2'h1;
                        pclk[e] = 1'b1;
                    end else if (clk_en) begin
                        exp_q[2*e+:2] = nxt(req[4*e+:4], exp_q[2*e+:2], pclk[e]);
                        pclk[e] = req[4*e+2];
                    end
                end
                rst_n <= ($urandom % 97) != 0;
                clk_en <= t == 0 || ($urandom % 8) != 0;
                req <= t == 0 ? 8'($urandom) : ($urandom % 2 && t == 2) ? 8'h00
                    : 8'($urandom) | 8'h33;
                #1 chk(elem_out, exp_q);
            end
            $display("test %0d done", t);
        end
        end_sim;
    end
endmodule
`default_nettype wire
